// ### rtl/sec_counter_pkg.sv
`default_nettype none

package sec_counter_pkg;

    // ==========================================================
    // register map, byte addresses on the wishbone bus
    localparam int ADDR_WIDTH = 4;
    localparam logic [3:0] OFF_TIMER_MODE = 4'h0;
    localparam logic [3:0] OFF_ALARM_COMPARE = 4'h4;
    localparam logic [3:0] OFF_COUNT_VALUE = 4'h8;
    localparam logic [3:0] OFF_EVENT_FLAGS = 4'hC;

    // ==========================================================
    // timer_mode fields
    localparam int PRESCALE_LSB = 0;
    localparam int PRESCALE_WIDTH = 16;
    localparam int ALARM_IRQ_ENABLE_BIT = 16;
    localparam int INCREMENT_IRQ_ENABLE_BIT = 17;
    localparam int COUNTER_RESTART_BIT = 18;
    localparam int MODE_STORED_WIDTH = 18;

    // ==========================================================
    // event_flags fields
    localparam int ALARM_FLAG_BIT = 0;
    localparam int INCREMENT_FLAG_BIT = 1;

    // ==========================================================
    // reset values
    localparam logic [31:0] TIMER_MODE_RESET = 32'h0000_8000;
    localparam logic [31:0] ALARM_COMPARE_RESET = 32'hFFFF_FFFF;
    localparam logic [31:0] COUNT_VALUE_RESET = 32'h0000_0000;

    // ==========================================================
    // timing
    localparam logic [16:0] ZERO_PRESCALE_PERIOD = 17'h1_0000;
    localparam logic [1:0] SLOW_EDGE_DELAY = 2'h2;

endpackage

`default_nettype wire

// ### rtl/slow_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// brings the slow clock into sys_clk and marks each rising edge
module slow_edge_sync (
    // system
    input wire logic sys_clk,
    input wire logic nrst,
    // slow clock pin
    input wire logic slowClock,
    // one-cycle pulse per slow rising edge
    output logic slowTick
);
    logic syncFirst;
    logic syncSecond;
    logic syncLast;
    logic next_syncFirst;
    logic next_syncSecond;
    logic next_syncLast;

    // the first stage feeds only the second, so no metastable value reaches logic
    always_comb begin
        next_syncFirst = slowClock;
        next_syncSecond = syncFirst;
        next_syncLast = syncSecond;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            syncFirst <= 1'b0;
            syncSecond <= 1'b0;
            syncLast <= 1'b0;
        end else begin
            syncFirst <= next_syncFirst;
            syncSecond <= next_syncSecond;
            syncLast <= next_syncLast;
        end
    end

    // edge detect looks only at settled stages
    assign slowTick = syncSecond & ~syncLast; // [R15]

endmodule
`default_nettype wire

// ### rtl/prescale_divider.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// divides slow ticks by the prescale period
module prescale_divider (
    // system
    input wire logic sys_clk,
    input wire logic nrst,
    // control
    input wire logic slowTick,
    input wire logic reload,
    input wire logic [15:0] prescalePeriod,
    // one-cycle pulse when the counter should advance
    output logic countIncrement
);
    import sec_counter_pkg::*;

    logic [16:0] divCount;
    logic [16:0] next_divCount;
    logic next_countIncrement;

    // zero means the full 16-bit span
    function automatic logic [16:0] eff_period(input logic [15:0] p);
        eff_period = (p == 16'h0000) ? ZERO_PRESCALE_PERIOD : {1'b0, p}; // [R02] [R03]
    endfunction

    // count slow ticks; a reload restarts the phase from zero
    always_comb begin
        next_divCount = divCount;
        next_countIncrement = 1'b0;
        if (reload) begin
            next_divCount = 17'h0_0000; // [R06]
        end else if (slowTick) begin
            if (divCount + 17'h0_0001 >= eff_period(prescalePeriod)) begin
                next_divCount = 17'h0_0000;
                next_countIncrement = 1'b1; // [R01]
            end else begin
                next_divCount = divCount + 17'h0_0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            divCount <= 17'h0_0000;
            countIncrement <= 1'b0;
        end else begin
            divCount <= next_divCount;
            countIncrement <= next_countIncrement;
        end
    end

    // ==========================================================
    // checks
    period_end_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R01]
        countIncrement |-> $past(divCount) + 17'h0_0001 >= $past(eff_period(prescalePeriod)))
        else $error("increment before the prescale period elapsed");
    wrap_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R02]
        slowTick && !reload && prescalePeriod == 16'h0000 && divCount == 17'h0_FFFF |=> countIncrement)
        else $error("zero prescale did not give a 65536 period");

endmodule
`default_nettype wire

// ### rtl/slow_clock_seconds_counter.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Overview of operation
// (R01) counter advances every prescale period slow ticks
// (R02) prescale zero means 65536 slow ticks
// (R03) nonzero prescale is the exact period
// (R04) mode bit 16 gates alarm flag interrupt
// (R05) mode bit 17 gates increment flag interrupt
// (R06) restart bit reloads divider, clears counter
// (R07) alarm when counter equals alarm value plus one
// (R08) value register reads count; writes ignored
// (R09) status bit 0: alarm since last read
// (R10) status bit 1: increment since last read
// (R11) counter is 32 bits and wraps
// (R12) status read clears flags two slow ticks later
// (R13) restart takes effect two slow ticks later
// (R14) single interrupt output from enabled flags
// (R15) slow clock synchronised into the bus clock
module slow_clock_seconds_counter (
    // system
    input wire logic sys_clk,
    input wire logic nrst,
    // slow clock input
    input wire logic slowClock,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [sec_counter_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt
    output logic irq
);
    import sec_counter_pkg::*;

    logic slowTick;
    logic countIncrement;
    logic [MODE_STORED_WIDTH-1:0] timerMode;
    logic [31:0] alarmCompare;
    logic [31:0] currentCount;
    logic alarmFlag;
    logic incrementFlag;
    logic [1:0] restartWait;
    logic [1:0] clearWait;
    logic [MODE_STORED_WIDTH-1:0] next_timerMode;
    logic [31:0] next_alarmCompare;
    logic [31:0] next_currentCount;
    logic next_alarmFlag;
    logic next_incrementFlag;
    logic [1:0] next_restartWait;
    logic [1:0] next_clearWait;
    logic next_irq;
    logic [31:0] next_rdata;
    logic next_ack;
    logic access;
    logic commit;
    logic modeWrite;
    logic restartRequest;
    logic statusRead;
    logic restartNow;
    logic clearNow;
    logic alarmHit;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] sel);
        logic [31:0] result;
        result = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                result[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        lane_merge = result;
    endfunction

    // ==========================================================
    // slow clock edge detection and divider
    slow_edge_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .slowClock(slowClock),
        .slowTick(slowTick)
    );

    prescale_divider u_divider (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .slowTick(slowTick),
        .reload(restartNow),
        .prescalePeriod(timerMode[PRESCALE_LSB +: PRESCALE_WIDTH]),
        .countIncrement(countIncrement)
    );

    // ==========================================================
    // bus decode; writes and read side effects land on the ack edge
    assign access = wb_cyc_i & wb_stb_i;
    assign commit = access & wb_ack_o;
    assign modeWrite = commit & wb_we_i & (wb_adr_i == OFF_TIMER_MODE);
    assign restartRequest = modeWrite & wb_sel_i[2] & wb_dat_i[COUNTER_RESTART_BIT];
    assign statusRead = commit & ~wb_we_i & (wb_adr_i == OFF_EVENT_FLAGS);
    // deferred actions fire on the second slow tick after their trigger
    assign restartNow = slowTick & (restartWait == 2'h1); // [R13]
    assign clearNow = slowTick & (clearWait == 2'h1); // [R12]
    // counter + 1 is the value after this step, compared with alarm + 1
    assign alarmHit = countIncrement & ~restartNow & (currentCount == alarmCompare); // [R07]

    // register file and read data; ack is one cycle, dropped after it is given
    always_comb begin
        next_ack = access & ~wb_ack_o;
        next_rdata = wb_dat_o;
        if (access && !wb_ack_o) begin
            case (wb_adr_i)
                OFF_TIMER_MODE: next_rdata = {14'h0000, timerMode};
                OFF_ALARM_COMPARE: next_rdata = alarmCompare;
                OFF_COUNT_VALUE: next_rdata = currentCount; // [R08]
                OFF_EVENT_FLAGS: next_rdata = {30'h0000_0000, incrementFlag, alarmFlag}; // [R09] [R10]
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_timerMode = timerMode;
        if (modeWrite) begin
            next_timerMode = MODE_STORED_WIDTH'(lane_merge({14'h0000, timerMode}, wb_dat_i, wb_sel_i));
        end
        next_alarmCompare = alarmCompare;
        if (commit && wb_we_i && wb_adr_i == OFF_ALARM_COMPARE) begin
            next_alarmCompare = lane_merge(alarmCompare, wb_dat_i, wb_sel_i);
        end
    end

    // deferred restart and flag clear, counted in slow ticks
    always_comb begin
        next_restartWait = restartWait;
        if (restartRequest) begin
            next_restartWait = SLOW_EDGE_DELAY; // [R06] [R13]
        end else if (slowTick && restartWait != 2'h0) begin
            next_restartWait = restartWait - 2'h1;
        end
        next_clearWait = clearWait;
        if (statusRead) begin
            next_clearWait = SLOW_EDGE_DELAY; // [R12]
        end else if (slowTick && clearWait != 2'h0) begin
            next_clearWait = clearWait - 2'h1;
        end
    end

    // counter, flags and interrupt; a set in the clearing cycle survives
    always_comb begin
        next_currentCount = currentCount;
        if (restartNow) begin
            next_currentCount = 32'h0000_0000; // [R06] [R13]
        end else if (countIncrement) begin
            next_currentCount = currentCount + 32'h0000_0001; // [R01] [R11]
        end
        next_alarmFlag = alarmHit | (alarmFlag & ~clearNow); // [R09]
        next_incrementFlag = (countIncrement & ~restartNow) | (incrementFlag & ~clearNow); // [R10]
        // next enables, so a mode write and the interrupt change on the same edge
        next_irq = (next_alarmFlag & next_timerMode[ALARM_IRQ_ENABLE_BIT]) // [R04] [R14]
                 | (next_incrementFlag & next_timerMode[INCREMENT_IRQ_ENABLE_BIT]); // [R05] [R14]
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            timerMode <= TIMER_MODE_RESET[MODE_STORED_WIDTH-1:0];
            alarmCompare <= ALARM_COMPARE_RESET;
            currentCount <= COUNT_VALUE_RESET;
            alarmFlag <= 1'b0;
            incrementFlag <= 1'b0;
            restartWait <= 2'h0;
            clearWait <= 2'h0;
            irq <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
        end else begin
            timerMode <= next_timerMode;
            alarmCompare <= next_alarmCompare;
            currentCount <= next_currentCount;
            alarmFlag <= next_alarmFlag;
            incrementFlag <= next_incrementFlag;
            restartWait <= next_restartWait;
            clearWait <= next_clearWait;
            irq <= next_irq;
            wb_dat_o <= next_rdata;
            wb_ack_o <= next_ack;
        end
    end

    // ==========================================================
    // checks: counter
    // apart from a restart, the count moves only on a divider pulse, by exactly one
    count_step_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R01]
        countIncrement && !restartNow |=> currentCount == $past(currentCount) + 32'h0000_0001)
        else $error("counter did not advance on increment");
    // bus writes to the value register must not disturb it
    count_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R08]
        !countIncrement && !restartNow |=> currentCount == $past(currentCount))
        else $error("counter changed without a cause");
    // the top value rolls over instead of saturating
    count_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
        countIncrement && !restartNow && currentCount == 32'hFFFF_FFFF |=> currentCount == 32'h0000_0000)
        else $error("counter did not wrap to zero");

    // ==========================================================
    // checks: restart
    // a restart write only arms the wait; the count keeps running meanwhile
    restart_delay_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
        restartRequest |=> restartWait == 2'h2 && currentCount == $past(currentCount) + {31'h0, $past(countIncrement)})
        else $error("restart acted before two slow ticks");
    // the pending restart waits for slow ticks, not for bus cycles
    restart_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R13]
        restartWait != 2'h0 && !slowTick && !restartRequest |=> restartWait == $past(restartWait))
        else $error("restart wait moved without a slow tick");
    // the readable count is zero right after the restart tick
    restart_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R06]
        restartNow |=> currentCount == 32'h0000_0000)
        else $error("restart did not clear the counter");
    // the divider is rephased, so the restart tick gives no step
    restart_phase_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R06]
        restartNow |=> !countIncrement)
        else $error("divider stepped on the restart tick");

    // ==========================================================
    // checks: flags
    // the alarm fires on the step that lands on alarm value plus one
    alarm_set_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R07]
        countIncrement && !restartNow && currentCount + 32'h0000_0001 == alarmCompare + 32'h0000_0001
        |=> alarmFlag)
        else $error("alarm match did not set the alarm flag");
    // no alarm flag without the count sitting on alarm value plus one
    alarm_rise_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R07]
        $rose(alarmFlag) && $stable(alarmCompare) |-> currentCount == alarmCompare + 32'h0000_0001)
        else $error("alarm flag set away from the match");
    // the alarm flag is sticky until its clear lands
    alarm_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R09]
        alarmFlag && !clearNow |=> alarmFlag)
        else $error("alarm flag dropped without a read");
    // a clear with no new match empties the alarm flag
    alarm_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R09]
        clearNow && !alarmHit |=> !alarmFlag)
        else $error("alarm flag survived its clear");
    // every step marks the increment flag
    inc_set_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
        countIncrement && !restartNow |=> incrementFlag)
        else $error("step did not set the increment flag");
    // the increment flag never appears without a step
    inc_rise_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
        $rose(incrementFlag) |-> $past(countIncrement) && !$past(restartNow))
        else $error("increment flag set without a step");
    // a clear with no step in the same cycle empties the increment flag
    flag_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
        clearNow && !countIncrement |=> !incrementFlag)
        else $error("increment flag survived its clear");
    // the increment flag is sticky until its clear lands
    flag_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
        incrementFlag && !clearNow |=> incrementFlag)
        else $error("increment flag dropped without a read");
    // a status read only arms the clear; software still sees the flags until it lands
    clear_arm_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
        statusRead |=> clearWait == SLOW_EDGE_DELAY)
        else $error("status read did not arm the deferred clear");
    // the read edge itself leaves the flags alone
    read_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
        statusRead && incrementFlag && !clearNow |=> incrementFlag)
        else $error("status read cleared a flag at once");

    // ==========================================================
    // checks: interrupt
    // flags and enables are registered together, so irq never lags a mode write
    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R14]
        irq == ((alarmFlag && timerMode[ALARM_IRQ_ENABLE_BIT])
             || (incrementFlag && timerMode[INCREMENT_IRQ_ENABLE_BIT])))
        else $error("interrupt does not match enabled flags");

    // ==========================================================
    // checks: bus
    // a full-word mode write stores every stored bit at once
    mode_store_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R04] [R05]
        modeWrite && wb_sel_i == 4'hF |=> timerMode == $past(wb_dat_i[MODE_STORED_WIDTH-1:0]))
        else $error("mode write did not store the written bits");
    // the restart bit is a pulse and never reads back
    mode_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R06]
        access && !wb_ack_o && wb_adr_i == OFF_TIMER_MODE |=> wb_dat_o[31:MODE_STORED_WIDTH] == 14'h0000)
        else $error("mode read shows bits above the stored field");
    // the value register returns the count of the cycle it was asked in
    value_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R08]
        access && !wb_ack_o && wb_adr_i == OFF_COUNT_VALUE |=> wb_ack_o && wb_dat_o == $past(currentCount))
        else $error("value read returned the wrong count");
    // the status register shows both flags in their own bits
    flags_read_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R09] [R10]
        access && !wb_ack_o && wb_adr_i == OFF_EVENT_FLAGS
        |=> wb_dat_o == {30'h0000_0000, $past(incrementFlag), $past(alarmFlag)})
        else $error("status read returned the wrong flags");
    // read data stands until the next access, read or write, so a slow master may sample late
    rdata_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(access && !wb_ack_o) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");
    // ack lasts one cycle and then drops for a cycle, even when the master keeps its strobe up
    ack_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// ### bench/test_slow_clock_seconds_counter.sv
`timescale 1ns/1ps
`default_nettype none

module test_slow_clock_seconds_counter;
    import sec_counter_pkg::*;

    // ==========================================================
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic slowClock = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADDR_WIDTH-1:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq;
    logic [3:0] slowDiv = 4'h0;
    logic [31:0] slowEdges = 32'h0000_0000;
    logic [31:0] q;
    int err_count = 0;
    int compares = 0;

    always #25 sys_clk = ~sys_clk;

    // slow clock of 16 system cycles, long enough for each level to pass the synchroniser
    always_ff @(posedge sys_clk) begin
        slowDiv <= slowDiv + 4'h1;
        if (slowDiv == 4'h7) begin
            slowClock <= 1'b1;
            slowEdges <= slowEdges + 32'h1;
        end
        if (slowDiv == 4'hF) begin
            slowClock <= 1'b0;
        end
    end

    slow_clock_seconds_counter i_dut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .slowClock(slowClock),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .irq(irq)
    );

    // ==========================================================
    // comparison and verdict
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
        compares++;
        if (seen !== expected) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, expected, seen);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // classic wishbone cycle; one idle cycle after release so calls never collide
    task automatic wb_access(input logic [3:0] adr, input logic we, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            check("bus ack", {31'h0, wb_ack_o}, 32'h1);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // polls the count until it leaves the given value; bounded so a stuck counter shows up
    task automatic wait_change(input logic [31:0] old);
        int k;
        k = 0;
        do begin
            wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
            k++;
        end while (q === old && k < 400);
        check("count moves", {31'h0, q !== old}, 32'h1);
    endtask

    task automatic wait_count(input logic [31:0] target);
        int k;
        k = 0;
        do begin
            wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
            k++;
        end while (q !== target && k < 400);
        check("count reached", q, target);
    endtask

    // slow edges between two successive count steps must equal the prescale period
    task automatic period_check(input logic [31:0] period);
        logic [31:0] e0;
        logic [31:0] c1;
        wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
        wait_change(q);
        e0 = slowEdges;
        c1 = q;
        wait_change(c1);
        check("period", slowEdges - e0, period);
        check("step", q, c1 + 32'h1);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        wb_access(OFF_TIMER_MODE, 1'b0, 32'h0);
        check("mode reset", q, 32'h0000_8000);
        wb_access(OFF_ALARM_COMPARE, 1'b0, 32'h0);
        check("alarm reset", q, 32'hFFFF_FFFF);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        check("flags reset", q, 32'h0000_0000);
        wb_access(4'h2, 1'b0, 32'h0);
        check("unmapped", q, 32'h0000_0000);
        wb_access(OFF_COUNT_VALUE, 1'b1, 32'h0000_1234);
        wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
        check("count write", q, 32'h0000_0000);
        // restart bit is a pulse and must not read back
        wb_access(OFF_TIMER_MODE, 1'b1, 32'h0007_0003);
        wb_access(OFF_TIMER_MODE, 1'b0, 32'h0);
        check("mode readback", q, 32'h0003_0003);
        period_check(32'h3);
        check("irq on inc", {31'h0, irq}, 32'h1);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        check("inc flag", q & 32'h2, 32'h2);
        wb_access(OFF_TIMER_MODE, 1'b1, 32'h0004_0001);
        // the restart lands two slow ticks later; measure only from the new phase
        wait_count(32'h0);
        period_check(32'h1);
        check("irq masked", {31'h0, irq}, 32'h0);
        // restart must not land before the second slow tick
        wb_access(OFF_TIMER_MODE, 1'b1, 32'h0004_0000);
        wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
        check("restart early", {31'h0, q != 32'h0}, 32'h1);
        repeat (48) @(posedge sys_clk);
        wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
        check("restart zero", q, 32'h0000_0000);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        repeat (48) @(posedge sys_clk);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        check("flags cleared", q, 32'h0000_0000);
        // zero prescale is a long period, not a stopped or every-tick divider
        repeat (640) @(posedge sys_clk);
        wb_access(OFF_COUNT_VALUE, 1'b0, 32'h0);
        check("zero prescale", q, 32'h0000_0000);
        wb_access(OFF_ALARM_COMPARE, 1'b1, 32'h0000_0004);
        wb_access(OFF_TIMER_MODE, 1'b1, 32'h0005_0003);
        wait_count(32'h3);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        wait_count(32'h4);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        check("no early alarm", q & 32'h1, 32'h0);
        check("irq quiet", {31'h0, irq}, 32'h0);
        wait_count(32'h5);
        check("irq alarm", {31'h0, irq}, 32'h1);
        wb_access(OFF_EVENT_FLAGS, 1'b0, 32'h0);
        check("alarm flags", q, 32'h0000_0003);
        test_done();
    end

    // watchdog well beyond the expected run of under fifteen hundred cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        test_done();
    end
endmodule

`default_nettype wire
